// File: logic/sfep_sync.v
// two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module sfep_sync #(
  parameter W = 3
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         rst_b_i,
  // asynchronous levels in, synchronised levels out
  input  wire [W-1:0] async_i,
  input  wire [W-1:0] rst_val_i,
  output wire [W-1:0] sync_o
);

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : bit_sync
      reg meta_reg;   // first stage, read only by the second
      reg sync_reg;   // second stage, safe to use
      // reset takes a constant 1; rst_val_i is never read
      always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          meta_reg <= 1'b1;
          sync_reg <= 1'b1;
        end else begin
          meta_reg <= async_i[g];
          sync_reg <= meta_reg;
        end
      end
      assign sync_o[g] = sync_reg;
    end
  endgenerate

endmodule

// File: logic/sfep_timer.v
// one-shot down counter for self-timed cycles
`timescale 1ns/1ps
module sfep_timer #(
  parameter W = 32
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         rst_b_i,
  // start a run of count_i cycles
  input  wire         load_i,
  input  wire [W-1:0] count_i,
  // one-cycle pulse when the run ends
  output reg          done_o
);

  reg [W-1:0] cnt_reg;   // cycles still to go
  reg         run_reg;   // a run is under way

  // load restarts; a count of zero still takes one cycle
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_reg <= {W{1'b0}};
      run_reg <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (load_i) begin
        cnt_reg <= count_i;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        if (cnt_reg <= {{(W-1){1'b0}}, 1'b1}) begin
          run_reg <= 1'b0;
          done_o  <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// File: logic/sfep_top.v
// serial flash erase and power-down command sequencer
//
// Overview of operation
// [R1] sector erase opcode clears 4 KB to FF
// [R2] host sends opcode then 24-bit address
// [R3] 32 KB block erase opcode clears block
// [R4] 64 KB block erase opcode clears block
// [R5] two chip erase opcodes, no address
// [R6] erase needs write enable latch set
// [R7] address erase commits only after bit 32
// [R8] single-byte commands commit only after bit 8
// [R9] chip select rise starts timed busy cycle
// [R10] read status answers during erase cycles
// [R11] finished erase clears write enable latch
// [R12] refuse sector or block erase if protected
// [R13] refuse chip erase if any range protected
// [R14] power-down entered within entry delay
// [R15] powered down: only release opcode recognised
// [R16] device starts in normal operation
// [R17] release opcode alone wakes after delay
// [R18] release plus dummies shifts identifier out
// [R19] identifier wake waits second release delay
// [R20] release ignored while busy
// [R21] erase the whole aligned region
// [R22] read status usable any time, repeats; the code gives no answer while powered down or in the release delay
`timescale 1ns/1ps
`include "sfep_defines.vh"
module sfep_top #(
  parameter        T_SE_US   = `SFEP_T_SE_US,
  parameter        T_BE1_US  = `SFEP_T_BE1_US,
  parameter        T_BE_US   = `SFEP_T_BE_US,
  parameter        T_CE_US   = `SFEP_T_CE_US,
  parameter        T_DP_NS   = `SFEP_T_DP_NS,
  parameter        T_RES1_NS = `SFEP_T_RES1_NS,
  parameter        T_RES2_NS = `SFEP_T_RES2_NS,
  parameter [23:0] ARRAY_BYTES = 24'h200000,
  parameter [7:0]  DEVICE_ID = 8'h5A  // arbitrary value
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_b_i,
  // serial link pins
  input  wire        spi_cs_b_i,
  input  wire        spi_clk_i,
  input  wire        serial_in_io_i,
  output reg         spi_do_o,
  output reg         spi_do_oe_b_o,
  // write enable control from the command decoder
  input  wire        wel_set_i,
  input  wire        wel_clr_i,
  // protection configuration
  input  wire        top_bottom_select_i,
  input  wire        protect_range_hi_i,
  input  wire        protect_range_mid_i,
  input  wire        protect_range_lo_i,
  input  wire        sector_granularity_select_i,
  // status
  output reg         busy_o,
  output reg         write_enable_latch_o,
  output reg         powered_down_o,
  output reg         cmd_refused_o,
  // erase requests toward the array
  output reg         erase_start_o,
  output reg  [23:0] erase_base_o,
  output reg  [1:0]  erase_size_o,
  output reg         erase_done_o
);

  // cycle counts derived from the times; ns times round down, never below one cycle
  localparam [31:0] SE_CYC   = T_SE_US  * `SFEP_CLK_MHZ;
  localparam [31:0] BE1_CYC  = T_BE1_US * `SFEP_CLK_MHZ;
  localparam [31:0] BE_CYC   = T_BE_US  * `SFEP_CLK_MHZ;
  localparam [31:0] CE_CYC   = T_CE_US  * `SFEP_CLK_MHZ;
  localparam [31:0] DP_CYC   = (T_DP_NS / `SFEP_CLK_NS) < 1 ? 1 :
                               (T_DP_NS / `SFEP_CLK_NS);
  localparam [31:0] RES1_CYC = (T_RES1_NS / `SFEP_CLK_NS) < 1 ? 1 :
                               (T_RES1_NS / `SFEP_CLK_NS);
  localparam [31:0] RES2_CYC = (T_RES2_NS / `SFEP_CLK_NS) < 1 ? 1 :
                               (T_RES2_NS / `SFEP_CLK_NS);

  // one-hot operating states
  localparam [4:0] ST_READY = 5'h01;  // normal, idle
  localparam [4:0] ST_ERASE = 5'h02;  // self-timed erase
  localparam [4:0] ST_ENTER = 5'h04;  // entering power-down
  localparam [4:0] ST_DOWN  = 5'h08;  // powered down
  localparam [4:0] ST_WAKE  = 5'h10;  // release delay

  // byte length of an erase size code
  function [23:0] size_len;
    input [1:0] sz;
    begin
      case (sz)
        `SFEP_SIZE_4K:  size_len = `SFEP_LEN_4K;
        `SFEP_SIZE_32K: size_len = `SFEP_LEN_32K;
        `SFEP_SIZE_64K: size_len = `SFEP_LEN_64K;
        default:        size_len = ARRAY_BYTES;
      endcase
    end
  endfunction

  // does [base, base+len) touch the protected range
  function prot_hit;
    input [23:0] base;
    input [23:0] len;
    input        tb;
    input [2:0]  bp;
    input        sec;
    reg   [24:0] psize;
    reg   [24:0] pstart;
    reg   [24:0] pend;
    begin
      psize = 25'h0000000;
      if (bp == 3'h7)
        psize = {1'b0, ARRAY_BYTES};
      else if (bp != 3'h0)
        psize = (sec ? 25'h0001000 : 25'h0010000) << (bp - 3'h1);
      if (psize > {1'b0, ARRAY_BYTES})
        psize = {1'b0, ARRAY_BYTES};
      pstart = tb ? 25'h0000000 : ({1'b0, ARRAY_BYTES} - psize);
      pend   = pstart + psize;
      prot_hit = (psize != 25'h0000000) &&
                 ({1'b0, base} < pend) &&
                 (({1'b0, base} + {1'b0, len}) > pstart);
    end
  endfunction

  // synchronised pins; nothing reads the raw pins
  wire [2:0] pin_s;
  wire       cs_b_s = pin_s[2];
  wire       sclk_s = pin_s[1];
  wire       din_s  = pin_s[0];

  sfep_sync #(
    .W         (3)
  ) u_sync (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .async_i   ({spi_cs_b_i, spi_clk_i, serial_in_io_i}),
    .rst_val_i (3'h7),
    .sync_o    (pin_s)
  );

  reg        cs_b_d_reg;   // previous chip select level
  reg        sclk_d_reg;   // previous link clock level
  wire       sclk_rise = sclk_s & ~sclk_d_reg;
  wire       sclk_fall = ~sclk_s & sclk_d_reg;
  wire       cs_rise   = cs_b_s & ~cs_b_d_reg;
  wire       cs_fall   = ~cs_b_s & cs_b_d_reg;

  reg  [4:0]  state_reg;      // operating state
  reg  [5:0]  bitcnt_reg;     // bits latched this frame, saturates
  reg  [31:0] shift_reg;      // opcode and address shifter
  reg         out_stat_reg;   // frame is returning status
  reg         out_id_reg;     // frame is returning the identifier
  reg  [2:0]  out_idx_reg;    // bit of the byte being sent
  reg         timer_load_reg; // start the timer
  reg  [31:0] timer_cnt_reg;  // cycles for the timer
  wire        timer_done;

  sfep_timer #(
    .W       (32)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .load_i  (timer_load_reg),
    .count_i (timer_cnt_reg),
    .done_o  (timer_done)
  );

  // first byte of the frame, frozen once the eighth bit is in;
  // a fixed shifter slice would lose it in short or long frames
  reg  [7:0]  opcode_reg;
  wire [7:0]  opcode = opcode_reg;
  wire [23:0] addr  = shift_reg[23:0];
  wire [2:0]  bp    = {protect_range_hi_i, protect_range_mid_i,
                       protect_range_lo_i};
  wire        down  = (state_reg == ST_DOWN) || (state_reg == ST_WAKE);

  // live status byte for read status
  wire [7:0] status_byte = {1'b0, sector_granularity_select_i,
                            top_bottom_select_i, bp,
                            write_enable_latch_o, busy_o};

  // decode of the committed command
  reg        is_erase;
  reg [1:0]  er_size;
  reg [31:0] er_cyc;
  reg        is_addr_cmd;
  always @* begin
    is_erase    = 1'b1;
    is_addr_cmd = 1'b1;
    er_size     = `SFEP_SIZE_4K;
    er_cyc      = SE_CYC;
    case (opcode)
      `SFEP_OP_SECTOR_ERASE: begin   // R1
        er_size = `SFEP_SIZE_4K;
        er_cyc  = SE_CYC;
      end
      `SFEP_OP_BLOCK32_ERASE: begin  // R3
        er_size = `SFEP_SIZE_32K;
        er_cyc  = BE1_CYC;
      end
      `SFEP_OP_BLOCK64_ERASE: begin  // R4
        er_size = `SFEP_SIZE_64K;
        er_cyc  = BE_CYC;
      end
      `SFEP_OP_CHIP_ERASE_A,
      `SFEP_OP_CHIP_ERASE_B: begin   // R5
        er_size     = `SFEP_SIZE_CHIP;
        er_cyc      = CE_CYC;
        is_addr_cmd = 1'b0;
      end
      default: begin
        is_erase    = 1'b0;
        is_addr_cmd = 1'b0;
      end
    endcase
  end

  // frame length that commits the command exactly
  wire exact_len = is_addr_cmd ? (bitcnt_reg == `SFEP_BITS_ADDR_CMD)  // R7
                               : (bitcnt_reg == `SFEP_BITS_OPCODE);   // R8
  // aligned base of the addressed region
  wire [23:0] er_len  = size_len(er_size);
  wire [23:0] er_base = (er_size == `SFEP_SIZE_CHIP) ? 24'h000000 :
                        (addr & ~(er_len - 24'h000001));              // R21
  wire er_prot = (er_size == `SFEP_SIZE_CHIP) ? (bp != 3'h0) :        // R13
                 prot_hit(er_base, er_len, top_bottom_select_i, bp,
                          sector_granularity_select_i);               // R12

  // edge history of the link pins
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_b_d_reg <= 1'b1;
      sclk_d_reg <= 1'b1;
    end else begin
      cs_b_d_reg <= cs_b_s;
      sclk_d_reg <= sclk_s;
    end
  end

  // input shifter, rising link clock edges, msb first
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bitcnt_reg <= 6'h00;
      shift_reg  <= 32'h00000000;
      opcode_reg <= 8'h00;
    end else if (cs_fall) begin
      bitcnt_reg <= 6'h00;
      shift_reg  <= 32'h00000000;
      opcode_reg <= 8'h00;                 // 00h decodes as no command
    end else if (!cs_b_s && sclk_rise) begin
      shift_reg <= {shift_reg[30:0], din_s};                          // R2
      if (bitcnt_reg == `SFEP_BITS_OPCODE - 6'd1)
        opcode_reg <= {shift_reg[6:0], din_s};                        // R2
      // saturate so overlong frames never alias to a legal length
      if (bitcnt_reg != 6'h3F)
        bitcnt_reg <= bitcnt_reg + 6'h01;
    end
  end

  // output side: status or identifier on falling link clock edges
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_stat_reg  <= 1'b0;
      out_id_reg    <= 1'b0;
      out_idx_reg   <= 3'h0;
      spi_do_o      <= 1'b0;
      spi_do_oe_b_o <= `SFEP_RST_DO_OE_B;
    end else if (cs_b_s) begin
      // pin released between frames
      out_stat_reg  <= 1'b0;
      out_id_reg    <= 1'b0;
      out_idx_reg   <= 3'h0;
      spi_do_oe_b_o <= 1'b1;
    end else begin
      if (bitcnt_reg == `SFEP_BITS_OPCODE &&
          shift_reg[7:0] == `SFEP_OP_READ_STATUS && !down)            // R15
        out_stat_reg <= 1'b1;                                         // R10 R22
      if (bitcnt_reg == `SFEP_BITS_ID_CMD &&
          shift_reg[31:24] == `SFEP_OP_RELEASE_ID && !busy_o &&       // R20
          state_reg != ST_WAKE)
        out_id_reg <= 1'b1;                                           // R18
      if (sclk_fall && (out_stat_reg || out_id_reg)) begin
        // byte repeats until chip select rises
        spi_do_o      <= out_id_reg ? DEVICE_ID[3'h7 - out_idx_reg]
                                    : status_byte[3'h7 - out_idx_reg];// R22
        spi_do_oe_b_o <= 1'b0;
        out_idx_reg   <= out_idx_reg + 3'h1;                          // R18
      end
    end
  end

  // command commit, self-timed cycles and power state
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg            <= ST_READY;                               // R16
      busy_o               <= 1'b0;
      powered_down_o       <= 1'b0;                                   // R16
      write_enable_latch_o <= `SFEP_RST_WEL;
      cmd_refused_o        <= 1'b0;
      erase_start_o        <= 1'b0;
      erase_base_o         <= 24'h000000;
      erase_size_o         <= `SFEP_SIZE_4K;
      erase_done_o         <= 1'b0;
      timer_load_reg       <= 1'b0;
      timer_cnt_reg        <= 32'h00000000;
    end else begin
      cmd_refused_o  <= 1'b0;
      erase_start_o  <= 1'b0;
      erase_done_o   <= 1'b0;
      timer_load_reg <= 1'b0;
      // latch is set by its own command, cleared by disable
      if (wel_set_i && !down)
        write_enable_latch_o <= 1'b1;
      else if (wel_clr_i && !down)
        write_enable_latch_o <= 1'b0;
      case (state_reg)
        ST_READY: begin
          if (cs_rise && is_erase) begin
            if (exact_len && write_enable_latch_o && !er_prot &&      // R6
                !wel_clr_i) begin
              state_reg      <= ST_ERASE;                             // R9
              busy_o         <= 1'b1;                                 // R9
              erase_start_o  <= 1'b1;
              erase_base_o   <= er_base;                              // R21
              erase_size_o   <= er_size;
              timer_load_reg <= 1'b1;
              timer_cnt_reg  <= er_cyc;                               // R9
            end else begin
              cmd_refused_o <= 1'b1;                                  // R7 R8
            end
          end else if (cs_rise && opcode == `SFEP_OP_POWER_DOWN) begin
            if (bitcnt_reg == `SFEP_BITS_OPCODE) begin                // R8
              state_reg      <= ST_ENTER;
              timer_load_reg <= 1'b1;
              timer_cnt_reg  <= DP_CYC;                               // R14
            end else begin
              cmd_refused_o <= 1'b1;
            end
          end
        end
        ST_ERASE: begin
          // only read status is answered here; the rest is dropped
          if (cs_rise && bitcnt_reg >= `SFEP_BITS_OPCODE &&
              opcode != `SFEP_OP_READ_STATUS)
            cmd_refused_o <= 1'b1;                                    // R20
          if (timer_done) begin
            state_reg    <= ST_READY;
            busy_o       <= 1'b0;                                     // R9
            erase_done_o <= 1'b1;
            // a set arriving in the same cycle wins
            if (!wel_set_i)
              write_enable_latch_o <= 1'b0;                           // R11
          end
        end
        ST_ENTER: begin
          if (timer_done) begin
            state_reg      <= ST_DOWN;
            powered_down_o <= 1'b1;                                   // R14
          end
        end
        ST_DOWN: begin
          if (cs_rise && bitcnt_reg >= `SFEP_BITS_OPCODE) begin
            if (opcode == `SFEP_OP_RELEASE_ID) begin                  // R15
              state_reg      <= ST_WAKE;
              timer_load_reg <= 1'b1;
              // plain release uses the first delay, id read the second
              timer_cnt_reg  <= (bitcnt_reg == `SFEP_BITS_OPCODE) ?
                                RES1_CYC : RES2_CYC;                  // R17 R19
            end else begin
              cmd_refused_o <= 1'b1;                                  // R15
            end
          end
        end
        ST_WAKE: begin
          // host keeps chip select high; an early frame is ignored
          if (cs_rise && bitcnt_reg >= `SFEP_BITS_OPCODE)
            cmd_refused_o <= 1'b1;                                    // R17
          if (timer_done) begin
            state_reg      <= ST_READY;                               // R17 R19
            powered_down_o <= 1'b0;
          end
        end
        default: begin
          state_reg      <= ST_READY;
          busy_o         <= 1'b0;
          powered_down_o <= 1'b0;
        end
      endcase
    end
  end

endmodule

// File: shared/sfep_defines.vh
// constants of the serial flash erase and power-down sequencer
`ifndef SFEP_DEFINES_VH
`define SFEP_DEFINES_VH

// instruction codes
`define SFEP_OP_SECTOR_ERASE   8'h20
`define SFEP_OP_BLOCK32_ERASE  8'h52
`define SFEP_OP_BLOCK64_ERASE  8'hD8
`define SFEP_OP_CHIP_ERASE_A   8'hC7
`define SFEP_OP_CHIP_ERASE_B   8'h60
`define SFEP_OP_POWER_DOWN     8'hB9
`define SFEP_OP_RELEASE_ID     8'hAB
`define SFEP_OP_READ_STATUS    8'h05

// bit counts that commit a command on chip select rising
`define SFEP_BITS_OPCODE       6'd8
`define SFEP_BITS_ADDR_CMD     6'd32
`define SFEP_BITS_ID_CMD       6'd32

// erase size codes
`define SFEP_SIZE_4K           2'h0
`define SFEP_SIZE_32K          2'h1
`define SFEP_SIZE_64K          2'h2
`define SFEP_SIZE_CHIP         2'h3

// region lengths in bytes
`define SFEP_LEN_4K            24'h001000
`define SFEP_LEN_32K           24'h008000
`define SFEP_LEN_64K           24'h010000

// status byte bit positions
`define SFEP_ST_BUSY           0
`define SFEP_ST_WEL            1
`define SFEP_ST_BP_LO          2
`define SFEP_ST_BP_HI          4
`define SFEP_ST_TB             5
`define SFEP_ST_SEC            6

// reset values
`define SFEP_RST_WEL           1'b0
`define SFEP_RST_DO_OE_B       1'b1

// clock rate and timing defaults
`define SFEP_CLK_MHZ           25
`define SFEP_CLK_NS            40
`define SFEP_T_SE_US           30000
`define SFEP_T_BE1_US          120000
`define SFEP_T_BE_US           150000
`define SFEP_T_CE_US           10000000
`define SFEP_T_DP_NS           3000
`define SFEP_T_RES1_NS         3000
`define SFEP_T_RES2_NS         1800

`endif

// File: tb/sfep_host_model.sv
// host serial master model driving the flash link pins
`timescale 1ns/1ps
module sfep_host_model (
  // pacing clock
  input  wire       clk_i,
  // link pins
  output reg        cs_b_o,
  output reg        sclk_o,
  output reg        mosi_o,
  input  wire       miso_i
);
  // idle: deselected, link clock parked low
  initial begin
    cs_b_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end
  // wait n falling edges of the system clock
  task gap(input integer n);
    begin
      repeat (n) @(negedge clk_i);
    end
  endtask
  // frame: nb bits out msb first, then nr bits in
  task xfer(input [39:0] d, input integer nb, input integer nr,
            output [7:0] q);
    integer i;
    begin
      q = 8'h00;
      cs_b_o = 1'b0;
      gap(4);
      for (i = 0; i < nb + nr; i = i + 1) begin
        sclk_o = 1'b0;
        // after the command the line toggles as dont-care
        mosi_o = (i < nb) ? d[39-i] : ~mosi_o;
        gap(4);
        sclk_o = 1'b1;
        gap(3);
        // sample late in the high phase, well after the device update
        if (i >= nb)
          q = {q[6:0], miso_i};
        gap(1);
      end
      sclk_o = 1'b0;
      gap(2);
      // deselect right after the last bit, then hold high
      cs_b_o = 1'b1;
      mosi_o = ~mosi_o;
      gap(8);
    end
  endtask
endmodule

// File: tb/sfep_top_bench.sv
// self-checking bench of the erase and power-down sequencer
`timescale 1ns/1ps
module sfep_top_bench;
  // bench driven inputs
  reg         clk = 1'b0;
  reg         rst_b = 1'b0;
  reg         wset = 1'b0;
  reg         wclr = 1'b0;
  reg  [2:0]  prot = 3'h0;
  reg         tb = 1'b0;
  reg         sec = 1'b0;
  // link and design outputs
  wire        cs_b, sclk, mosi, sdo, oe_b, busy, write_enable_latch, pd, refd, st, done;
  wire [23:0] base;
  wire [1:0]  size;
  // bookkeeping
  integer     miscompares = 0;
  integer     total_checks = 0;
  integer     n_st = 0;
  integer     n_ref = 0;
  integer     n_oe = 0;
  integer     k;
  reg  [23:0] l_base;
  reg  [1:0]  l_size;
  reg  [7:0]  q;
  // 25 MHz clock
  always #20 clk = ~clk;
  // sector time long enough to poll status while busy
  sfep_top #(.T_SE_US(20), .T_BE1_US(1), .T_BE_US(1), .T_CE_US(1))
  u_sfep_top (
    .clk_i(clk), .rst_b_i(rst_b), .spi_cs_b_i(cs_b), .spi_clk_i(sclk),
    .serial_in_io_i(mosi), .spi_do_o(sdo), .spi_do_oe_b_o(oe_b),
    .wel_set_i(wset), .wel_clr_i(wclr), .top_bottom_select_i(tb),
    .protect_range_hi_i(prot[2]), .protect_range_mid_i(prot[1]),
    .protect_range_lo_i(prot[0]), .sector_granularity_select_i(sec),
    .busy_o(busy), .write_enable_latch_o(write_enable_latch), .powered_down_o(pd),
    .cmd_refused_o(refd), .erase_start_o(st), .erase_base_o(base),
    .erase_size_o(size), .erase_done_o(done));
  sfep_host_model u_host (.clk_i(clk), .cs_b_o(cs_b), .sclk_o(sclk),
    .mosi_o(mosi), .miso_i(sdo));
  // one-cycle pulses are counted so no edge is missed
  always @(posedge clk) begin
    if (st === 1'b1) begin
      n_st = n_st + 1;
      l_base = base;
      l_size = size;
    end
    if (refd === 1'b1)
      n_ref = n_ref + 1;
    if (oe_b === 1'b0)
      n_oe = n_oe + 1;
  end
  // compare and count
  task chk(input [63:0] nm, input [23:0] e, input [23:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("Error %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // bounded waits on levels
  task wait_idle;
    begin
      for (k = 0; k < 1000 && busy !== 1'b0; k = k + 1)
        @(negedge clk);
    end
  endtask
  task wait_pd(input v);
    begin
      for (k = 0; k < 300 && pd !== v; k = k + 1)
        @(negedge clk);
    end
  endtask
  // one-shot latch pulse: set when w, clear otherwise
  task latch(input w);
    begin
      wset = w;
      wclr = ~w;
      @(negedge clk);
      wset = 1'b0;
      wclr = 1'b0;
    end
  endtask
  task status(output [7:0] r);
    begin
      u_host.xfer({8'h05, 32'h0}, 8, 8, r);
    end
  endtask
  // one erase attempt and its expected outcome
  task erase(input [7:0] op, input [23:0] a, input integer nb, input w,
             input ok, input [23:0] eb, input [1:0] es, input hold);
    integer s, r;
    begin
      s = n_st;
      r = n_ref;
      latch(w);
      u_host.xfer({op, a, 8'h00}, nb, 0, q);
      chk("start", ok, n_st - s);
      chk("refuse", !ok, n_ref - r);
      if (ok) begin
        chk("base", eb, l_base);
        chk("size", es, l_size);
        if (!hold) begin
          wait_idle;
          chk("latch", 1'b0, write_enable_latch);
        end
      end
    end
  endtask
  // main sequence
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    chk("down", 1'b0, pd);
    erase(8'h20, 24'h123456, 32, 1, 1, 24'h123000, 2'h0, 1);
    status(q);
    chk("status", 8'h03, q);
    k = n_ref;
    u_host.xfer({8'hAB, 32'h0}, 8, 0, q);
    chk("ignored", k + 1, n_ref);
    chk("busy", 1'b1, busy);
    wait_idle;
    chk("latch", 1'b0, write_enable_latch);
    erase(8'h52, 24'h0ABCDE, 32, 1, 1, 24'h0A8000, 2'h1, 0);
    erase(8'hD8, 24'h1FFFFF, 32, 1, 1, 24'h1F0000, 2'h2, 0);
    erase(8'hC7, 24'h0, 8, 1, 1, 24'h0, 2'h3, 0);
    erase(8'h60, 24'h0, 8, 1, 1, 24'h0, 2'h3, 0);
    erase(8'h20, 24'h0, 32, 0, 0, 24'h0, 2'h0, 0);
    erase(8'h20, 24'h0, 31, 1, 0, 24'h0, 2'h0, 0);
    erase(8'h20, 24'h0, 33, 1, 0, 24'h0, 2'h0, 0);
    erase(8'hC7, 24'h800000, 9, 1, 0, 24'h0, 2'h0, 0);
    // bottom 64 KB protected in 4 KB units
    tb = 1'b1;
    sec = 1'b1;
    prot = 3'h5;
    latch(0);
    status(q);
    chk("status", 8'h74, q);
    erase(8'h20, 24'h00F123, 32, 1, 0, 24'h0, 2'h0, 0);
    erase(8'h20, 24'h010FFF, 32, 1, 1, 24'h010000, 2'h0, 0);
    erase(8'h60, 24'h0, 8, 1, 0, 24'h0, 2'h0, 0);
    prot = 3'h0;
    latch(0);
    u_host.xfer({8'hB9, 32'h0}, 8, 0, q);
    wait_pd(1);
    chk("down", 1'b1, pd);
    k = n_oe;
    status(q);
    chk("silent", k, n_oe);
    erase(8'h20, 24'h0, 32, 1, 0, 24'h0, 2'h0, 0);
    u_host.xfer({8'hAB, 32'h0}, 8, 0, q);
    wait_pd(0);
    chk("down", 1'b0, pd);
    k = n_oe;
    status(q);
    chk("answer", 1'b1, n_oe > k);
    chk("status", 8'h60, q);
    u_host.xfer({8'hB9, 32'h0}, 8, 0, q);
    wait_pd(1);
    u_host.xfer({8'hAB, 32'h0}, 32, 8, q);
    chk("id", 8'h5A, q);
    wait_pd(0);
    chk("down", 1'b0, pd);
    report_and_stop;
  end
  // watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk);
    miscompares = miscompares + 1;
    report_and_stop;
  end
  // verdict and end of run
  task report_and_stop;
    begin
      if (miscompares == 0 && total_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
endmodule

// File: tb/sfep_top_props.sv
// concurrent checks on the ports of the erase and power-down sequencer
`timescale 1ns/1ps
module sfep_top_props (
  // clock and reset
  input wire        clk_i,
  input wire        rst_b_i,
  // side inputs
  input wire        wel_set_i,
  input wire        protect_range_hi_i,
  input wire        protect_range_mid_i,
  input wire        protect_range_lo_i,
  // watched outputs
  input wire        busy_o,
  input wire        write_enable_latch_o,
  input wire        powered_down_o,
  input wire        erase_start_o,
  input wire [23:0] erase_base_o,
  input wire [1:0]  erase_size_o,
  input wire        erase_done_o
);
  // one domain, so clock and reset are stated once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // erase launch, then the start of its busy span
  sequence start_s;
    erase_start_o && busy_o;
  endsequence
  sequence run_s;
    busy_o [*8];
  endsequence
  start_busy_a: assert property (erase_start_o |-> start_s ##1 run_s)
    else $error("busy did not follow erase start");
  done_bound_a: assert property (erase_start_o |-> ##[1:1000] erase_done_o)
    else $error("erase cycle never ended");
  done_drop_a: assert property (erase_done_o |-> !busy_o && $past(busy_o))
    else $error("busy not dropped with done");
  wel_clear_a: assert property (erase_done_o && !wel_set_i
    |-> !write_enable_latch_o) else $error("latch kept after erase");
  need_wel_a: assert property (erase_start_o |-> $past(write_enable_latch_o))
    else $error("erase started without latch");
  // base must sit on the boundary of its region size
  base_align_a: assert property (erase_start_o |-> (erase_size_o == 2'h0 ?
    erase_base_o[11:0] == 12'h000 : erase_size_o == 2'h1 ?
    erase_base_o[14:0] == 15'h0000 : erase_size_o == 2'h2 ?
    erase_base_o[15:0] == 16'h0000 : erase_base_o == 24'h000000))
    else $error("erase base not aligned");
  chip_prot_a: assert property (erase_start_o && erase_size_o == 2'h3 |->
    {protect_range_hi_i, protect_range_mid_i, protect_range_lo_i} == 3'h0)
    else $error("chip erase under protection");
  no_restart_a: assert property (busy_o && $past(busy_o) |-> !erase_start_o)
    else $error("new erase during busy");
  down_idle_a: assert property (powered_down_o |-> !busy_o && !erase_start_o)
    else $error("activity while powered down");
  boot_normal_a: assert property ($rose(rst_b_i) |-> !powered_down_o)
    else $error("powered down after reset");
endmodule

bind sfep_top sfep_top_props u_sfep_top_props (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .wel_set_i(wel_set_i),
  .protect_range_hi_i(protect_range_hi_i),
  .protect_range_mid_i(protect_range_mid_i),
  .protect_range_lo_i(protect_range_lo_i), .busy_o(busy_o),
  .write_enable_latch_o(write_enable_latch_o),
  .powered_down_o(powered_down_o), .erase_start_o(erase_start_o),
  .erase_base_o(erase_base_o), .erase_size_o(erase_size_o),
  .erase_done_o(erase_done_o)
);
